// ==== core/ipbm_pkg.sv ====
/*
  Constants and types for the interleaved PCM bus multiplexer of one framer.
  Assumes the framer's receive elastic store supplies channel bytes on request.
*/
// Behaviour
// - Bus carries two, four or eight streams at 4.096, 8.192, 16.384 MHz.
// - Each framer owns one exclusive bus position; no position is shared.
// - One common 8 kHz sync from backplane or first device; others input.
// - After the frame sync each framer waits for its three-bit slot.
// - Channel interleave places one channel per framer in turn, whole frame.
// - Channel interleave tolerates asynchronous framers; elastic stores absorb slips.
// - Drive strobe is low while this framer occupies the bus.
// - Frame interleave places one complete frame per framer in turn.
// - Config bits 0 to 2 hold this framer's slot number.
// - Config bit 3 set enables interleaved bus operation, clear disables it.
// - Config bit 4 clear selects channel interleave, set selects frame interleave.
// - Config bits 5 and 6 give device count, setting rate and slots.
package ipbm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned IPBM_ADDR_W = 4;
  localparam logic [IPBM_ADDR_W-1:0] IPBM_CFG_OFS = 4'h0;
  localparam logic [IPBM_ADDR_W-1:0] IPBM_CTRL_OFS = 4'h1;
  localparam logic [IPBM_ADDR_W-1:0] IPBM_STAT_OFS = 4'h2;
  localparam logic [IPBM_ADDR_W-1:0] IPBM_FCNT_OFS = 4'h3;
  localparam logic [7:0] IPBM_CFG_RST = 8'h00;
  localparam logic [7:0] IPBM_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Device count encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] IPBM_POP_TWO = 2'h0;
  localparam logic [1:0] IPBM_POP_FOUR = 2'h1;
  localparam logic [1:0] IPBM_POP_EIGHT = 2'h2;
  localparam logic [1:0] IPBM_POP_RSVD = 2'h3;
  localparam logic [2:0] IPBM_LAST_TWO = 3'h1;
  localparam logic [2:0] IPBM_LAST_FOUR = 3'h3;
  localparam logic [2:0] IPBM_LAST_EIGHT = 3'h7;

  // ----------------------------------------------------------------
  // Frame shape
  // ----------------------------------------------------------------
  localparam int unsigned IPBM_DEF_CHANNELS = 32;
  localparam int unsigned IPBM_MAX_CHANNELS = 32;
  localparam logic [2:0] IPBM_LAST_BIT = 3'h7;
  localparam logic [2:0] IPBM_FETCH_BIT = 3'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {IPBM_KIND_CHAN, IPBM_KIND_FRAME} ipbm_kind_t;

  typedef struct packed {
    logic unused7;
    logic [1:0] population;
    logic kind;
    logic on;
    logic [2:0] slot;
  } ipbm_cfg_t;

  typedef struct packed {
    logic [6:0] unused;
    logic sync_master;
  } ipbm_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [IPBM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } ipbm_reg_req_t;

  typedef struct packed {
    logic [4:0] chan;
    logic [2:0] dev;
  } ipbm_pos_t;

endpackage

// ==== core/ipbm_mux.sv ====
/*
  Interleaved PCM bus multiplexer for one framer: position tracking against the
  common frame sync, byte fetch from the receive elastic store, serial drive
  and drive strobe. Assumes core_clk_i is several times faster than the bus
  clock it samples, and the elastic store answers a read in the next cycle.
*/
`timescale 1ns/100ps
module ipbm_mux #(
  parameter int unsigned CHANNELS = ipbm_pkg::IPBM_DEF_CHANNELS
) (
  input wire logic core_clk_i,                          // Core clock
  input wire logic rstn_i,                              // Async reset, low
  input wire ipbm_pkg::ipbm_reg_req_t reg_req_i,        // Register strobes
  output logic [7:0] reg_rdata_o,                       // Read data
  input wire logic bus_clk_i,                           // Backplane bit clock
  input wire logic fsync_i,                             // Frame sync pin in
  output logic fsync_o,                                 // Frame sync pin out
  output logic fsync_oe_n_o,                            // Sync drive, low
  output logic bus_data_o,                              // Serial PCM out
  output logic bus_drive_strobe_n_o,                    // Bus occupied, low
  output logic es_rd_req_o,                             // Store read pulse
  output logic [4:0] es_rd_chan_o,                      // Channel to read
  input wire logic [7:0] es_rd_data_i                   // Store byte
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CHANNELS < 1 || CHANNELS > ipbm_pkg::IPBM_MAX_CHANNELS) begin : g_bad_channels
    $error("ipbm_mux: CHANNELS out of range");
  end

  localparam logic [4:0] LAST_CHAN = 5'(CHANNELS - 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  ipbm_pkg::ipbm_cfg_t cfg_r;
  ipbm_pkg::ipbm_ctrl_t ctrl_r;
  logic [7:0] fcnt_r;
  logic locked_r;
  logic [7:0] rdata_r;
  logic [7:0] stat_w;
  logic pop_bad;
  logic active;
  logic [2:0] last_dev;
  ipbm_pkg::ipbm_kind_t kind;

  // ----------------------------------------------------------------
  // Config decode
  // ----------------------------------------------------------------

  always_comb begin
    case (cfg_r.population)
      ipbm_pkg::IPBM_POP_TWO: last_dev = ipbm_pkg::IPBM_LAST_TWO;
      ipbm_pkg::IPBM_POP_FOUR: last_dev = ipbm_pkg::IPBM_LAST_FOUR;
      ipbm_pkg::IPBM_POP_EIGHT: last_dev = ipbm_pkg::IPBM_LAST_EIGHT;
      default: last_dev = ipbm_pkg::IPBM_LAST_TWO;
    endcase
  end

  // Reserved count parks the block like a disable
  assign pop_bad = (cfg_r.population == ipbm_pkg::IPBM_POP_RSVD);
  assign active = cfg_r.on && !pop_bad;
  assign kind = cfg_r.kind ? ipbm_pkg::IPBM_KIND_FRAME : ipbm_pkg::IPBM_KIND_CHAN;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_r <= ipbm_pkg::IPBM_CFG_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == ipbm_pkg::IPBM_CFG_OFS) begin
      cfg_r <= reg_req_i.wdata;
      cfg_r.unused7 <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= ipbm_pkg::IPBM_CTRL_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == ipbm_pkg::IPBM_CTRL_OFS) begin
      ctrl_r <= {7'h00, reg_req_i.wdata[0]};
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------

  // Status: sync seen, own slot now, reserved count
  assign stat_w = {5'h00, pop_bad, !bus_drive_strobe_n_o, locked_r};

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ipbm_pkg::IPBM_CFG_OFS: rdata_r <= cfg_r;
        ipbm_pkg::IPBM_CTRL_OFS: rdata_r <= ctrl_r;
        ipbm_pkg::IPBM_STAT_OFS: rdata_r <= stat_w;
        ipbm_pkg::IPBM_FCNT_OFS: rdata_r <= fcnt_r;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      // Idle cycles read zero, so read data stand one cycle only
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic bclk_s1_r;
  logic bclk_s2_r;
  logic bclk_s3_r;
  logic fs_s1_r;
  logic fs_s2_r;
  logic fs_edge_r;
  logic bclk_rise;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
    end else begin
      bclk_s1_r <= bus_clk_i;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fs_s1_r <= 1'b0;
      fs_s2_r <= 1'b0;
    end else begin
      fs_s1_r <= fsync_i;
      fs_s2_r <= fs_s1_r;
    end
  end

  // Third stage only remembers the last synced level
  assign bclk_rise = bclk_s2_r && !bclk_s3_r;

  // Sync level as seen at the previous bus edge
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fs_edge_r <= 1'b0;
    end else if (bclk_rise) begin
      fs_edge_r <= fs_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus position tracking
  // ----------------------------------------------------------------
  logic [2:0] bit_r;
  ipbm_pkg::ipbm_pos_t pos_r;
  logic [2:0] bit_nxt;
  ipbm_pkg::ipbm_pos_t pos_nxt;
  ipbm_pkg::ipbm_pos_t ahead;
  logic frame_end;
  logic sync_start;

  function automatic ipbm_pkg::ipbm_pos_t advance(input ipbm_pkg::ipbm_pos_t p,
                                                  input ipbm_pkg::ipbm_kind_t k,
                                                  input logic [2:0] ld);
    ipbm_pkg::ipbm_pos_t n;
    n = p;
    if (k == ipbm_pkg::IPBM_KIND_CHAN) begin
      if (p.dev == ld) begin
        n.dev = 3'h0;
        n.chan = (p.chan == LAST_CHAN) ? 5'h00 : p.chan + 5'h01;
      end else begin
        n.dev = p.dev + 3'h1;
      end
    end else begin
      if (p.chan == LAST_CHAN) begin
        n.chan = 5'h00;
        n.dev = (p.dev == ld) ? 3'h0 : p.dev + 3'h1;
      end else begin
        n.chan = p.chan + 5'h01;
      end
    end
    return n;
  endfunction

  function automatic logic owns(input ipbm_pkg::ipbm_pos_t p, input logic act,
                                input logic [2:0] slot);
    return act && (p.dev == slot);
  endfunction

  assign frame_end = (bit_r == ipbm_pkg::IPBM_LAST_BIT) && (pos_r.chan == LAST_CHAN)
                     && (pos_r.dev == last_dev);
  // master follows own wrap, others follow the pin
  assign sync_start = ctrl_r.sync_master ? frame_end : (fs_s2_r && !fs_edge_r);
  // Next position, so its byte is fetched before it is due
  assign ahead = advance(pos_r, kind, last_dev);

  always_comb begin
    bit_nxt = bit_r;
    pos_nxt = pos_r;
    if (!active) begin
      bit_nxt = 3'h0;
      pos_nxt = '0;
    end else if (sync_start) begin
      bit_nxt = 3'h0;
      pos_nxt = '0;
    end else if (bit_r == ipbm_pkg::IPBM_LAST_BIT) begin
      bit_nxt = 3'h0;
      pos_nxt = ahead;
    end else begin
      bit_nxt = bit_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_r <= 3'h0;
      pos_r <= '0;
    end else if (bclk_rise || !active) begin
      bit_r <= bit_nxt;
      pos_r <= pos_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Lock, frame count and sync drive
  // ----------------------------------------------------------------

  // Sync seen since enable, and frame count
  // Count wraps freely; software takes differences
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      locked_r <= 1'b0;
      fcnt_r <= 8'h00;
    end else if (!active) begin
      locked_r <= 1'b0;
    end else if (bclk_rise && sync_start) begin
      locked_r <= 1'b1;
      fcnt_r <= fcnt_r + 8'h01;
    end
  end

  // master drives sync during bit 0
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fsync_o <= 1'b0;
      fsync_oe_n_o <= 1'b1;
    end else begin
      // Enable follows the mode at once, value only at bus edges
      fsync_oe_n_o <= !(ctrl_r.sync_master && active);
      if (bclk_rise) begin
        fsync_o <= ctrl_r.sync_master && active && sync_start;
      end
    end
  end

  // ----------------------------------------------------------------
  // Elastic store fetch
  // ----------------------------------------------------------------
  logic req_r;
  logic req_d_r;
  logic [4:0] chan_r;
  logic [7:0] fetch_r;

  // bytes come from the elastic store, slips handled there
  // Fetch at bit 3 leaves the store five bit times to answer
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_r <= 1'b0;
      req_d_r <= 1'b0;
      chan_r <= 5'h00;
    end else begin
      req_d_r <= req_r;
      req_r <= 1'b0;
      if (bclk_rise && active && !sync_start && bit_nxt == ipbm_pkg::IPBM_FETCH_BIT
          && owns(ahead, active, cfg_r.slot)) begin
        req_r <= 1'b1;
        chan_r <= ahead.chan;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_r <= 8'h00;
    end else if (req_d_r) begin
      fetch_r <= es_rd_data_i;
    end
  end

  assign es_rd_req_o = req_r;
  assign es_rd_chan_o = chan_r;

  // ----------------------------------------------------------------
  // Serial drive
  // ----------------------------------------------------------------
  logic [7:0] shift_r;
  logic own_nxt;

  assign own_nxt = owns(pos_nxt, active, cfg_r.slot);

  // one bit per bus clock, rate set by the backplane
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_r <= 8'h00;
      bus_data_o <= 1'b0;
    end else if (!active) begin
      shift_r <= 8'h00;
      bus_data_o <= 1'b0;
    end else if (bclk_rise) begin
      // Back-to-back own bytes reload with no gap
      if (own_nxt && bit_nxt == 3'h0) begin
        shift_r <= fetch_r;
        bus_data_o <= fetch_r[7];
      end else if (own_nxt) begin
        shift_r <= {shift_r[6:0], 1'b0};
        bus_data_o <= shift_r[6];
      end else begin
        // Line held low outside own slots
        bus_data_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_drive_strobe_n_o <= 1'b1;
    end else if (!active) begin
      bus_drive_strobe_n_o <= 1'b1;
    end else if (bclk_rise) begin
      bus_drive_strobe_n_o <= !own_nxt;
    end
  end

endmodule // ipbm_mux

// ==== testbench/ipbm_mux_props.sv ====
/*
  Port assertions for the interleaved PCM bus multiplexer.
  Assumes binding to ipbm_mux; shadows config and control in helper logic.
*/
`timescale 1ns/100ps
module ipbm_mux_props (
  input wire logic core_clk_i,                    // Core clock
  input wire logic rstn_i,                        // Reset, low
  input wire ipbm_pkg::ipbm_reg_req_t reg_req_i,  // Register strobes
  input wire logic [7:0] reg_rdata_o,             // Read data
  input wire logic fsync_oe_n_o,                  // Sync drive, low
  input wire logic bus_data_o,                    // Serial out
  input wire logic bus_drive_strobe_n_o,          // Bus occupied, low
  input wire logic es_rd_req_o                    // Store read
);
  logic [7:0] cfg_r;
  logic ctrl_r;
  logic [2:0] last;
  assign last = (cfg_r[6:5] == 2'h0) ? 3'h1 : (cfg_r[6:5] == 2'h1) ? 3'h3 : 3'h7;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) cfg_r <= 8'h00;
    else if (reg_req_i.wr && reg_req_i.addr == 4'h0) cfg_r <= reg_req_i.wdata & 8'h7f;
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) ctrl_r <= 1'b0;
    else if (reg_req_i.wr && reg_req_i.addr == 4'h1) ctrl_r <= reg_req_i.wdata[0];
  end
  logic strobe_d_r;
  logic cfg_chg_r;
  // Any register write may end a slot early; held until the next slot starts
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strobe_d_r <= 1'b1;
      cfg_chg_r <= 1'b0;
    end else begin
      strobe_d_r <= bus_drive_strobe_n_o;
      if (reg_req_i.wr) begin
        cfg_chg_r <= 1'b1;
      end else if (strobe_d_r && !bus_drive_strobe_n_o) begin
        cfg_chg_r <= 1'b0;
      end
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_read_idle: assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
    else $error("read data not zero when idle");
  chk_cfg_read: assert property ((reg_req_i.rd && reg_req_i.addr == 4'h0)
    |=> reg_rdata_o == $past(cfg_r)) else $error("config readback wrong");
  chk_unmapped_read: assert property ((reg_req_i.rd && reg_req_i.addr > 4'h3)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_quiet_data: assert property (bus_drive_strobe_n_o |-> !bus_data_o)
    else $error("data driven outside own slot");
  chk_off_idle: assert property (!cfg_r[3] [*3] |-> bus_drive_strobe_n_o)
    else $error("bus driven while disabled");
  chk_rsvd_idle: assert property ((cfg_r[6:5] == 2'h3) [*3] |-> bus_drive_strobe_n_o)
    else $error("bus driven with reserved count");
  chk_slot_range: assert property ((cfg_r[2:0] > last) [*3] |-> bus_drive_strobe_n_o)
    else $error("slot beyond bus size drives");
  chk_slave_sync: assert property (!ctrl_r [*3] |-> fsync_oe_n_o)
    else $error("sync driven while following");
  chk_byte_hold: assert property ($fell(bus_drive_strobe_n_o)
    |-> (!bus_drive_strobe_n_o || cfg_chg_r) [*8]) else $error("strobe too short");
  chk_fetch_pulse: assert property (es_rd_req_o |=> !es_rd_req_o)
    else $error("store read not a pulse");
endmodule // ipbm_mux_props

bind ipbm_mux ipbm_mux_props chk_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .fsync_oe_n_o(fsync_oe_n_o),
  .bus_data_o(bus_data_o), .bus_drive_strobe_n_o(bus_drive_strobe_n_o),
  .es_rd_req_o(es_rd_req_o));

// ==== testbench/ipbm_far_end.sv ====
/*
  Backplane and elastic store model: bit clock, common frame sync, store bytes.
  Assumes frame_bits_i is the bus bit count of one frame.
*/
`timescale 1ns/100ps
module ipbm_far_end (
  input wire logic core_clk_i,          // Core clock
  input wire logic [7:0] frame_bits_i,  // Bits per frame
  input wire logic es_rd_req_i,         // Store read pulse
  input wire logic [4:0] es_rd_chan_i,  // Channel to read
  output logic bus_clk_o,               // Backplane bit clock
  output logic fsync_o,                 // Common frame sync
  output logic [7:0] bit_idx_o,         // Bit in frame
  output logic [7:0] es_rd_data_o       // Store byte
);
  logic held_r;
  // one backplane clock, phase unrelated to core
  initial begin
    bus_clk_o = 1'b0;
    bit_idx_o = 8'h00;
    #37;
    forever #400 bus_clk_o = ~bus_clk_o;
  end
  always @(negedge bus_clk_o) begin
    bit_idx_o <= (bit_idx_o + 8'h01 >= frame_bits_i) ? 8'h00 : bit_idx_o + 8'h01;
  end
  assign fsync_o = (bit_idx_o == 8'h00);
  // store enabled, byte valid for the request and answer cycles only
  always @(posedge core_clk_i) held_r <= es_rd_req_i;
  assign es_rd_data_o = (es_rd_req_i || held_r) ? {3'h5, es_rd_chan_i} : ~{3'h5, es_rd_chan_i};
endmodule // ipbm_far_end

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for ipbm_mux with a two-channel frame.
  Assumes the far end model supplies bus clock, sync and store bytes.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int CH = 2;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  ipbm_pkg::ipbm_reg_req_t reg_req_i = '0;
  logic [7:0] reg_rdata_o, es_data, far_bits, bit_idx, cfg;
  logic bus_clk, far_sync, fsync_o, fsync_oe_n_o, bus_data_o, strobe_n, es_req, mon;
  logic [4:0] es_chan;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int own_bits;
  always #50 core_clk_i = ~core_clk_i;
  ipbm_mux #(.CHANNELS(CH)) dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .bus_clk_i(bus_clk),
    .fsync_i(fsync_oe_n_o ? far_sync : fsync_o), .fsync_o(fsync_o),
    .fsync_oe_n_o(fsync_oe_n_o), .bus_data_o(bus_data_o), .bus_drive_strobe_n_o(strobe_n),
    .es_rd_req_o(es_req), .es_rd_chan_o(es_chan), .es_rd_data_i(es_data));
  ipbm_far_end far_u (.core_clk_i(core_clk_i), .frame_bits_i(far_bits),
    .es_rd_req_i(es_req), .es_rd_chan_i(es_chan), .bus_clk_o(bus_clk),
    .fsync_o(far_sync), .bit_idx_o(bit_idx), .es_rd_data_o(es_data));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      $display("FAIL %0t %s", $time, msg);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i) reg_req_i <= ipbm_pkg::ipbm_reg_req_t'({2'b10, a, d});
    @(posedge core_clk_i) reg_req_i <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i) reg_req_i <= ipbm_pkg::ipbm_reg_req_t'({2'b01, a, 8'h00});
    @(posedge core_clk_i) reg_req_i <= '0;
    #1 d = reg_rdata_o;
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // Bit-by-bit slot monitor
  always @(posedge bus_clk) if (mon) begin : mon_b
    int p, pos, n, dev, ch;
    logic own;
    logic [7:0] byt;
    p = (int'(bit_idx) + int'(far_bits) - 1) % int'(far_bits);
    pos = p / 8;
    n = int'(far_bits) / (8 * CH);
    ch = cfg[4] ? pos % CH : pos / n;
    dev = cfg[4] ? pos / CH : pos % n;
    own = cfg[3] && cfg[6:5] != 2'h3 && dev == int'(cfg[2:0]);
    own_bits += int'(own);
    byt = {3'h5, 5'(ch)};
    chk({6'h00, strobe_n, bus_data_o},
      {6'h00, !own, own && byt[7 - p % 8]}, "slot bit wrong");
  end
  task automatic run_cfg(input logic [7:0] c, input int exp_bits);
    cfg = c;
    far_bits = 8'(((c[6:5] == 2'h3) ? 2 : (2 << c[6:5])) * CH * 8);
    wr(4'h0, c);
    repeat (int'(far_bits) * 16 + 16) @(posedge core_clk_i);
    own_bits = 0;
    mon = 1'b1;
    repeat (int'(far_bits) * 8) @(posedge core_clk_i);
    mon = 1'b0;
    chk(8'(own_bits), 8'(exp_bits), "own bit count");
  endtask
  task automatic t_regs();
    logic [7:0] d;
    rd(4'h0, d);
    chk(d, 8'h00, "config reset");
    wr(4'h0, 8'h7f);
    rd(4'h0, d);
    chk(d, 8'h7f, "config readback");
    rd(4'h2, d);
    chk(d, 8'h04, "reserved count status");
    wr(4'h1, 8'hff);
    rd(4'h1, d);
    chk(d, 8'h01, "control readback");
    wr(4'h1, 8'h00);
    wr(4'hf, 8'h55);
    rd(4'hf, d);
    chk(d, 8'h00, "unmapped read");
    wr(4'h0, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    for (int k = 0; k < 2; k++) begin
      for (int pop = 0; pop < 3; pop++) begin
        run_cfg({1'b0, 2'(pop), 1'(k), 1'b1, 3'((2 << pop) - 1)}, 8 * CH);
      end
    end
    $display("t_modes done");
  endtask
  task automatic t_idle();
    run_cfg(8'h01, 0);
    run_cfg(8'h68, 0);
    run_cfg(8'h0b, 0);
    $display("t_idle done");
  endtask
  task automatic t_master();
    int t;
    logic [7:0] d;
    logic [7:0] a;
    run_cfg(8'h08, 8 * CH);
    rd(4'h2, d);
    chk(d & 8'h05, 8'h01, "status after lock");
    rd(4'h3, a);
    repeat (254) @(posedge core_clk_i);
    rd(4'h3, d);
    chk(d, 8'(a + 8'h01), "frame count step");
    wr(4'h1, 8'h01);
    t = 0;
    while (!fsync_o && t < 600) @(posedge core_clk_i) t++;
    while (fsync_o && t < 600) @(posedge core_clk_i) t++;
    t = 0;
    while (!fsync_o && t < 600) @(posedge core_clk_i) t++;
    chk(8'(t > 246 && t < 258), 8'h01, "master frame length");
    chk({7'h00, fsync_oe_n_o}, 8'h00, "sync not driven");
    wr(4'h1, 8'h00);
    repeat (4) @(posedge core_clk_i);
    chk({7'h00, fsync_oe_n_o}, 8'h01, "sync still driven");
    $display("t_master done");
  endtask
  initial begin
    mon = 1'b0;
    cfg = 8'h00;
    far_bits = 8'd32;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_modes();
    t_idle();
    t_master();
    end_of_test();
  end
endmodule // tb_top
